// file: common/nvs_pkg.sv
// Purpose: Shared constants and types for the serial NVM erase/write sequencer
// Assumes: 10 MHz system clock, programming clock sampled as a plain input
// Notes: Times are in microseconds; cycle counts derive from them
package nvs_pkg;
    // ************************************************
    // Serial framing
    // ************************************************
    localparam int CMD_BITS = 4;
    localparam int OPER_BITS = 16;
    localparam logic [4:0] FRAME_LAST = 5'h13;
    localparam logic [4:0] CMD_LAST = 5'h03;
    localparam logic [4:0] OUT_LOAD = 5'h0B;
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_SHIFT_OUT = 4'h2;
    localparam logic [3:0] CMD_TBL_WR = 4'hC;

    // ************************************************
    // Core instruction subset
    // ************************************************
    localparam logic [7:0] OP_MOVLW = 8'h0E;
    localparam logic [7:0] OP_MOVWF = 8'h6E;
    localparam logic [7:0] OP_CLRF = 8'h6A;
    localparam logic [7:0] OP_MOVF_W = 8'h50;
    localparam logic [3:0] OP_BSF = 4'h8;
    localparam logic [3:0] OP_BCF = 4'h9;

    // ************************************************
    // File addresses and control bits
    // ************************************************
    localparam logic [7:0] F_CTRL = 8'hA6;
    localparam logic [7:0] F_TBL_U = 8'hF8;
    localparam logic [7:0] F_TBL_H = 8'hF7;
    localparam logic [7:0] F_TBL_L = 8'hF6;
    localparam logic [7:0] F_TLATCH = 8'hF5;
    localparam logic [7:0] F_EE_LO = 8'hA9;
    localparam logic [7:0] F_EE_HI = 8'hAA;
    localparam logic [7:0] F_EE_DATA = 8'hA8;
    localparam int B_PGM_SEL = 7;
    localparam int B_CFG_SEL = 6;
    localparam int B_FREE = 4;
    localparam int B_WRITE_ENABLE_BIT = 2;
    localparam int B_WR = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ************************************************
    // Bulk erase option locations and values, row erase mask and start fall count
    // ************************************************
    localparam logic [21:0] OPT_LO_ADDR = 22'h3C0004;
    localparam logic [21:0] OPT_HI_ADDR = 22'h3C0005;
    localparam logic [7:0] BULK_LO_VAL = 8'h8F;
    localparam logic [7:0] BULK_HI_VAL = 8'h0F;
    localparam logic [21:0] ROW_MASK = 22'h3FFFC0;
    localparam logic [4:0] START_FALLS = 5'h18;

    // ************************************************
    // Self-timed durations
    // ************************************************
    localparam int CLK_MHZ = 10;
    localparam int ROW_ERASE_US = 1000;
    localparam int EE_PHASE_US = 2000;
    localparam int BULK_ERASE_US = 5000;
    localparam int ROW_ERASE_CYC = ROW_ERASE_US * CLK_MHZ;
    localparam int EE_PHASE_CYC = EE_PHASE_US * CLK_MHZ;
    localparam int BULK_ERASE_CYC = BULK_ERASE_US * CLK_MHZ;

    typedef enum logic [2:0] {
        NVS_OP_NONE,
        NVS_OP_BULK,
        NVS_OP_ROW,
        NVS_OP_EE_ERASE,
        NVS_OP_EE_WRITE
    } nvs_op_type;

    typedef struct packed {
        logic [3:0] cmd;
        logic [15:0] operand;
    } nvs_instr_type;

    typedef struct packed {
        logic strobe;
        nvs_op_type op;
        logic [21:0] addr;
        logic [7:0] data;
    } nvs_nvm_cmd_type;
endpackage

// file: design/nvs_serial_port.sv
// Purpose: Serial frame engine on the programming clock and data pins
// Assumes: Pins are asynchronous; both pass two flip-flops first
// Notes: Output data is driven on rising edges, input taken on falling
`timescale 1ns/10ps
module nvs_serial_port (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic hold_i,
    input wire logic prog_clock_pin_i,
    input wire logic prog_data_pin_i,
    input wire logic [7:0] out_byte_i,
    output logic fall_o,
    output logic instr_valid_o,
    output nvs_pkg::nvs_instr_type instr_o,
    output logic prog_data_pin_o,
    output logic prog_data_pin_oe_o
);
    logic clk_s1_r, clk_s2_r, clk_s3_r, dat_s1_r, dat_s2_r;
    logic [19:0] sr_r;
    logic [4:0] cnt_r;
    logic [3:0] cmd_r;
    logic [7:0] sh_r;
    logic valid_r, out_r, oe_r;
    nvs_pkg::nvs_instr_type instr_r;

    wire fall = clk_s3_r & ~clk_s2_r;
    wire rise = ~clk_s3_r & clk_s2_r;
    wire out_phase = (cmd_r == nvs_pkg::CMD_SHIFT_OUT) && (cnt_r > nvs_pkg::OUT_LOAD);

    // ************************************************
    // Synchronisers
    // ************************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {clk_s1_r, clk_s2_r, clk_s3_r, dat_s1_r, dat_s2_r} <= 5'h00;
        end else begin
            {clk_s1_r, clk_s2_r, clk_s3_r} <= {prog_clock_pin_i, clk_s1_r, clk_s2_r};
            {dat_s1_r, dat_s2_r} <= {prog_data_pin_i, dat_s1_r};
        end
    end

    // ************************************************
    // Frame capture
    // ************************************************
    // 20-bit LSb-first frames
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sr_r <= 20'h00000;
            cnt_r <= 5'h00;
            cmd_r <= 4'h0;
            valid_r <= 1'b0;
            instr_r <= '0;
        end else begin
            valid_r <= 1'b0;
            if (hold_i) begin
                cnt_r <= 5'h00;
                cmd_r <= 4'h0;
            end else if (fall) begin
                sr_r <= {dat_s2_r, sr_r[19:1]};
                cnt_r <= (cnt_r == nvs_pkg::FRAME_LAST) ? 5'h00 : cnt_r + 5'h01;
                if (cnt_r == nvs_pkg::CMD_LAST) begin
                    cmd_r <= {dat_s2_r, sr_r[19:17]};
                end
                if (cnt_r == nvs_pkg::FRAME_LAST) begin
                    valid_r <= 1'b1;
                    instr_r <= {cmd_r, dat_s2_r, sr_r[19:5]};
                end
            end
        end
    end

    // ************************************************
    // Shift-out of the table latch
    // ************************************************
    // latch driven on last eight clocks
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_r <= 8'h00;
            out_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (hold_i || (fall && cnt_r == nvs_pkg::FRAME_LAST)) begin
            oe_r <= 1'b0;
        end else if (fall && cnt_r == nvs_pkg::OUT_LOAD) begin
            sh_r <= out_byte_i;
        end else if (rise && out_phase) begin
            out_r <= sh_r[0];
            sh_r <= {1'b0, sh_r[7:1]};
            oe_r <= 1'b1;
        end
    end

    assign fall_o = fall & ~hold_i;
    assign instr_valid_o = valid_r;
    assign instr_o = instr_r;
    assign prog_data_pin_o = out_r;
    assign prog_data_pin_oe_o = oe_r;

    a_frame_length: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        valid_r |-> $past(cnt_r) == nvs_pkg::FRAME_LAST)
        else $error("frame ended off the twentieth clock");
    a_out_cmd_only: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        oe_r |-> cmd_r == nvs_pkg::CMD_SHIFT_OUT)
        else $error("data pin driven outside shift-out");
endmodule // nvs_serial_port

// file: design/nvs_sequencer.sv
// Purpose: Device-side erase and data EEPROM write sequencer behind serial pins
// Assumes: Programmer keeps its own sequence; array is outside this block
// Notes: Array is outside; the block only emits command strobes
// Summary of operation
// - Lower location then gets full-chip value; device erases everything.
// - Row erase starts on fourth clock of second NOP after start.
// - EEPROM written one byte via address pair and latch, erase first.
// - Both select bits clear direct the write to data EEPROM.
// - Writes accepted only while write enable is set.
// - Start bit launches write using current address and data latch.
// - Write begins on 24th falling clock; start bit cleared at end.
// - Instruction is 4-bit command plus 16-bit operand, LSb first.
// - Command 0000 runs a core instruction; 0010 shifts latch out.
`timescale 1ns/10ps
module nvs_sequencer #(
    parameter int ROW_CYC = nvs_pkg::ROW_ERASE_CYC,
    parameter int EE_CYC = nvs_pkg::EE_PHASE_CYC,
    parameter int BULK_CYC = nvs_pkg::BULK_ERASE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic prog_clock_pin_i,
    input wire logic prog_data_pin_i,
    output logic prog_data_pin_o,
    output logic prog_data_pin_oe_o,
    output nvs_pkg::nvs_nvm_cmd_type nvm_cmd_o,
    output logic nvm_busy_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ERASE, ST_WRITE} nvs_state_type;

    nvs_state_type state_r, state_nxt;
    nvs_pkg::nvs_op_type op_r, op_nxt;
    nvs_pkg::nvs_instr_type instr;
    nvs_pkg::nvs_nvm_cmd_type cmd_r;
    logic [7:0] ctrl_r, ctrl_nxt, wreg_r, tbl_u_r, tbl_h_r, tbl_l_r, tlatch_r;
    logic [7:0] ee_lo_r, ee_hi_r, ee_data_r, opt_lo_r, opt_hi_r, sw_ctrl;
    logic [4:0] falls_r;
    logic [23:0] timer_r, timer_nxt;
    logic fall, valid;

    nvs_serial_port u_port (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .hold_i(state_r == ST_ERASE && op_r == nvs_pkg::NVS_OP_BULK),
        .prog_clock_pin_i(prog_clock_pin_i),
        .prog_data_pin_i(prog_data_pin_i),
        .out_byte_i(tlatch_r),
        .fall_o(fall),
        .instr_valid_o(valid),
        .instr_o(instr),
        .prog_data_pin_o(prog_data_pin_o),
        .prog_data_pin_oe_o(prog_data_pin_oe_o)
    );

    // ************************************************
    // Core instruction decode
    // ************************************************
    function automatic logic file_hit(input logic en, input logic [7:0] f, input logic [7:0] a);
        file_hit = en && (f == a);
    endfunction

    wire [7:0] op_hi = instr.operand[15:8];
    wire [7:0] fsel = instr.operand[7:0];
    wire is_core = valid && instr.cmd == nvs_pkg::CMD_CORE;
    wire is_movlw = is_core && op_hi == nvs_pkg::OP_MOVLW;
    wire is_movf = is_core && op_hi == nvs_pkg::OP_MOVF_W && fsel == nvs_pkg::F_CTRL;
    wire is_store = is_core && (op_hi == nvs_pkg::OP_MOVWF || op_hi == nvs_pkg::OP_CLRF);
    wire [7:0] store_val = (op_hi == nvs_pkg::OP_CLRF) ? 8'h00 : wreg_r;
    wire is_bsf = is_core && instr.operand[15:12] == nvs_pkg::OP_BSF && fsel == nvs_pkg::F_CTRL;
    wire is_bcf = is_core && instr.operand[15:12] == nvs_pkg::OP_BCF && fsel == nvs_pkg::F_CTRL;
    wire [2:0] bit_idx = instr.operand[11:9];
    wire [7:0] bit_mask = 8'h01 << bit_idx;
    wire [21:0] tbl_ptr = {tbl_u_r[5:0], tbl_h_r, tbl_l_r};
    wire is_tblwr = valid && instr.cmd == nvs_pkg::CMD_TBL_WR;
    wire opt_lo_we = is_tblwr && tbl_ptr == nvs_pkg::OPT_LO_ADDR;
    wire opt_hi_we = is_tblwr && tbl_ptr == nvs_pkg::OPT_HI_ADDR;
    wire bulk_go = opt_lo_we && instr.operand[7:0] == nvs_pkg::BULK_LO_VAL
        && opt_hi_r == nvs_pkg::BULK_HI_VAL;
    wire busy = state_r != ST_IDLE;
    wire phase_end = (state_r == ST_ERASE || state_r == ST_WRITE) && timer_r == 24'h000000;
    wire launch = state_r == ST_WAIT && fall && falls_r == nvs_pkg::START_FALLS - 5'h01;
    // Refused target clears the start bit at launch, else it would stick
    wire done = (phase_end && !(state_r == ST_ERASE && op_r == nvs_pkg::NVS_OP_EE_ERASE))
        || (launch && op_r == nvs_pkg::NVS_OP_NONE);
    // start only with write enable already set
    wire wr_go = !ctrl_r[nvs_pkg::B_WR] && sw_ctrl[nvs_pkg::B_WR] && ctrl_r[nvs_pkg::B_WRITE_ENABLE_BIT];
    wire ee_target = ctrl_r[nvs_pkg::B_PGM_SEL:nvs_pkg::B_CFG_SEL] == 2'b00;
    wire row_target = ctrl_r[nvs_pkg::B_PGM_SEL] && !ctrl_r[nvs_pkg::B_CFG_SEL]
        && ctrl_r[nvs_pkg::B_FREE];

    // ************************************************
    // Control register next value
    // ************************************************
    always_comb begin
        sw_ctrl = ctrl_r;
        if (file_hit(is_store, fsel, nvs_pkg::F_CTRL)) begin
            sw_ctrl = store_val;
        end else if (is_bsf) begin
            sw_ctrl = ctrl_r | bit_mask;
        end else if (is_bcf) begin
            sw_ctrl = ctrl_r & ~bit_mask;
        end
        ctrl_nxt = sw_ctrl;
        if (ctrl_r[nvs_pkg::B_WR]) begin
            ctrl_nxt[nvs_pkg::B_WR] = !done;
        end else begin
            ctrl_nxt[nvs_pkg::B_WR] = wr_go && !busy;
        end
    end

    // ************************************************
    // Operation sequencing
    // ************************************************
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        timer_nxt = (timer_r != 24'h000000) ? timer_r - 24'h000001 : timer_r;
        unique case (state_r)
            ST_IDLE: begin
                if (bulk_go) begin
                    state_nxt = ST_WAIT;
                    op_nxt = nvs_pkg::NVS_OP_BULK;
                end else if (wr_go) begin
                    state_nxt = ST_WAIT;
                    op_nxt = ee_target ? nvs_pkg::NVS_OP_EE_ERASE
                        : (row_target ? nvs_pkg::NVS_OP_ROW : nvs_pkg::NVS_OP_NONE);
                end
            end
            ST_WAIT: begin
                if (launch) begin
                    state_nxt = (op_r == nvs_pkg::NVS_OP_NONE) ? ST_IDLE : ST_ERASE;
                    unique case (op_r)
                        nvs_pkg::NVS_OP_BULK: timer_nxt = 24'(BULK_CYC - 1);
                        nvs_pkg::NVS_OP_ROW: timer_nxt = 24'(ROW_CYC - 1);
                        default: timer_nxt = 24'(EE_CYC - 1);
                    endcase
                end
            end
            ST_ERASE: begin
                if (phase_end) begin
                    state_nxt = (op_r == nvs_pkg::NVS_OP_EE_ERASE) ? ST_WRITE : ST_IDLE;
                    op_nxt = (op_r == nvs_pkg::NVS_OP_EE_ERASE) ? nvs_pkg::NVS_OP_EE_WRITE : op_r;
                    timer_nxt = 24'(EE_CYC - 1);
                end
            end
            ST_WRITE: begin
                if (phase_end) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // ************************************************
    // Array command, one strobe per phase
    // ************************************************
    // operation type picks the address: masked row pointer, zero, or the EEPROM address pair
    wire [21:0] ee_addr = {12'h000, ee_hi_r[1:0], ee_lo_r};
    wire [21:0] op_addr = (op_nxt == nvs_pkg::NVS_OP_ROW) ? (tbl_ptr & nvs_pkg::ROW_MASK)
        : ((op_nxt == nvs_pkg::NVS_OP_BULK) ? 22'h000000 : ee_addr);
    wire strobe = (state_nxt == ST_ERASE && state_r != ST_ERASE)
        || (state_nxt == ST_WRITE && state_r != ST_WRITE);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_r <= '0;
        end else begin
            cmd_r <= {strobe, strobe ? op_nxt : cmd_r.op, strobe ? op_addr : cmd_r.addr,
                strobe ? ee_data_r : cmd_r.data};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= ST_IDLE;
            op_r <= nvs_pkg::NVS_OP_NONE;
            timer_r <= 24'h000000;
            falls_r <= 5'h00;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            timer_r <= timer_nxt;
            falls_r <= (state_r != ST_WAIT) ? 5'h00 : falls_r + 5'(fall);
        end
    end

    // ************************************************
    // Core-visible registers
    // ************************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= nvs_pkg::CTRL_RESET;
            {wreg_r, tbl_u_r, tbl_h_r, tbl_l_r, tlatch_r} <= 40'h0000000000;
            {ee_lo_r, ee_hi_r, ee_data_r, opt_lo_r, opt_hi_r} <= 40'h0000000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (is_movlw) wreg_r <= fsel;
            if (is_movf) wreg_r <= ctrl_r;
            if (file_hit(is_store, fsel, nvs_pkg::F_TBL_U)) tbl_u_r <= store_val;
            if (file_hit(is_store, fsel, nvs_pkg::F_TBL_H)) tbl_h_r <= store_val;
            if (file_hit(is_store, fsel, nvs_pkg::F_TBL_L)) tbl_l_r <= store_val;
            if (file_hit(is_store, fsel, nvs_pkg::F_TLATCH)) tlatch_r <= store_val;
            if (file_hit(is_store, fsel, nvs_pkg::F_EE_LO)) ee_lo_r <= store_val;
            if (file_hit(is_store, fsel, nvs_pkg::F_EE_HI)) ee_hi_r <= store_val;
            if (file_hit(is_store, fsel, nvs_pkg::F_EE_DATA)) ee_data_r <= store_val;
            if (opt_lo_we) opt_lo_r <= instr.operand[7:0];
            if (opt_hi_we) opt_hi_r <= instr.operand[15:8];
        end
    end

    assign nvm_cmd_o = cmd_r;
    assign nvm_busy_o = busy;

    // ************************************************
    // Checks
    // ************************************************
    a_wr_needs_write_enable_bit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(ctrl_r[nvs_pkg::B_WR]) |-> $past(ctrl_r[nvs_pkg::B_WRITE_ENABLE_BIT]))
        else $error("start bit set without write enable");
    a_launch_on_24: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == ST_WAIT && state_nxt != ST_WAIT)
        |-> fall && falls_r == nvs_pkg::START_FALLS - 5'h01)
        else $error("operation left wait off the 24th fall");
    a_row_strobe: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cmd_r.strobe && cmd_r.op == nvs_pkg::NVS_OP_ROW |-> $past(state_r == ST_WAIT))
        else $error("row erase strobe without wait");
    a_wr_held_busy: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (busy && op_r != nvs_pkg::NVS_OP_BULK) |-> ctrl_r[nvs_pkg::B_WR])
        else $error("start bit dropped while busy");
    a_wr_clears: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (done && ctrl_r[nvs_pkg::B_WR]) |=> !ctrl_r[nvs_pkg::B_WR] && state_r == ST_IDLE)
        else $error("start bit not cleared at completion");
    a_ee_erase_first: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cmd_r.strobe && cmd_r.op == nvs_pkg::NVS_OP_EE_WRITE
        |-> $past(state_r) == ST_ERASE && $past(op_r) == nvs_pkg::NVS_OP_EE_ERASE)
        else $error("EEPROM store without erase phase");
    a_ee_target: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cmd_r.strobe && cmd_r.op == nvs_pkg::NVS_OP_EE_ERASE
        |-> ctrl_r[7:6] == 2'b00 && cmd_r.addr == ee_addr)
        else $error("EEPROM erase with wrong target or address");
    a_bulk_value: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cmd_r.strobe && cmd_r.op == nvs_pkg::NVS_OP_BULK
        |-> opt_hi_r == nvs_pkg::BULK_HI_VAL && opt_lo_r == nvs_pkg::BULK_LO_VAL)
        else $error("bulk erase without full-chip option");
endmodule // nvs_sequencer

// file: bench/nvs_programmer.sv
// Purpose: Programmer model driving the serial clock and data pins
// Assumes: Called at a falling system clock edge; half period 4 cycles
// Notes: Released data line toggles so stale levels never match
`timescale 1ns/10ps
module nvs_programmer (
    input wire logic ref_clk_i,
    input wire logic dev_data_i,
    input wire logic dev_oe_i,
    output logic prog_clock_pin_o,
    output logic prog_data_pin_o
);
    // Discharge hold time in system clocks, plain default
    localparam int DISCHARGE_CYC = 40;
    logic drive_r = 1'b0;
    initial prog_clock_pin_o = 1'b0;
    assign prog_data_pin_o = dev_oe_i ? dev_data_i : drive_r;
    task automatic half();
        repeat (4) @(negedge ref_clk_i);
    endtask
    task automatic frame(input logic [3:0] cmd, input logic [15:0] oper,
                         output logic [7:0] rd);
        logic [19:0] bits;
        bits = {oper, cmd};
        rd = 8'h00;
        for (int i = 0; i < 20; i++) begin
            prog_clock_pin_o = 1'b1;
            drive_r = (cmd == 4'h2 && i >= 12) ? ~drive_r : bits[i];
            half();
            // Taken before the falling edge: the device drops its enable after the 20th
            if (cmd == 4'h2 && i >= 12) begin
                rd = {prog_data_pin_o, rd[7:1]};
            end
            prog_clock_pin_o = 1'b0;
            half();
        end
    endtask
    task automatic discharge();
        repeat (DISCHARGE_CYC) @(negedge ref_clk_i);
    endtask
endmodule // nvs_programmer

// file: bench/nvs_sequencer_tb.sv
// Purpose: Self-checking bench for the erase and EEPROM write sequencer
// Assumes: Short self-timed durations of 20 cycles
// Notes: Strobes are checked against a queue of expected commands
`timescale 1ns/10ps
module nvs_sequencer_tb;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic prog_clock_pin, prog_data_pin, dout, doe, busy;
    logic [7:0] rd, lo, dat;
    logic [1:0] hi;
    logic [31:0] seed = 32'h01739850;
    nvs_pkg::nvs_nvm_cmd_type cmd, exp;
    nvs_pkg::nvs_nvm_cmd_type exp_q[$];
    int bad_count = 0;
    int total_checks = 0;
    initial forever #50 ref_clk_i = ~ref_clk_i;
    nvs_sequencer #(.ROW_CYC(20), .EE_CYC(20), .BULK_CYC(20)) dut (.ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i), .prog_clock_pin_i(prog_clock_pin), .prog_data_pin_i(prog_data_pin),
        .prog_data_pin_o(dout), .prog_data_pin_oe_o(doe), .nvm_cmd_o(cmd), .nvm_busy_o(busy));
    nvs_programmer prog (.ref_clk_i(ref_clk_i), .dev_data_i(dout), .dev_oe_i(doe),
        .prog_clock_pin_o(prog_clock_pin), .prog_data_pin_o(prog_data_pin));
    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic core(input logic [15:0] w);
        prog.frame(4'h0, w, rd);
    endtask
    task automatic note(input nvs_pkg::nvs_op_type op, input logic [21:0] a, input logic [7:0] d);
        exp_q.push_back({1'b1, op, a, d});
    endtask
    task automatic poll(input logic [7:0] want);
        core(16'h50A6);
        core(16'h6EF5);
        core(16'h0000);
        prog.frame(4'h2, 16'h0000, rd);
        check(rd, want);
    endtask
    task automatic launch(input int left);
        core(16'h82A6);
        core(16'h0000);
        check(exp_q.size(), left);
    endtask
    // Monitor off the clock edge to avoid update races
    always @(negedge ref_clk_i) begin
        if (cmd.strobe === 1'b1) begin
            exp = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
            check({cmd.op, cmd.addr}, {exp.op, exp.addr});
            if (exp.op inside {nvs_pkg::NVS_OP_EE_ERASE, nvs_pkg::NVS_OP_EE_WRITE}) begin
                check(cmd.data, exp.data);
            end
        end
    end
    initial begin
        #5000000;
        bad_count++;
        final_report();
    end
    // ************************************************
    // Scenarios
    // ************************************************
    initial begin
        repeat (3) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            {dat, hi, lo} = seed[17:0];
            core(16'h9EA6);
            core(16'h9CA6);
            core({8'h0E, lo});
            core(16'h6EA9);
            core({14'h0380, hi});
            core(16'h6EAA);
            core({8'h0E, dat});
            core(16'h6EA8);
            core(16'h84A6);
            note(nvs_pkg::NVS_OP_EE_ERASE, {12'h000, hi, lo}, dat);
            note(nvs_pkg::NVS_OP_EE_WRITE, {12'h000, hi, lo}, dat);
            core(16'h82A6);
            check(busy, 1);
            core(16'h82A6);
            check(exp_q.size(), 2);
            core(16'h0000);
            check(exp_q.size(), 0);
            poll(8'h04); // WR cleared, WRITE_ENABLE_BIT kept
            prog.discharge();
            core(16'h94A6);
            $display("test ee write %0d done", k);
        end
        core(16'h82A6);
        core(16'h0000);
        core(16'h0000);
        poll(8'h00);
        $display("test start without enable done");
        core(16'h8EA6);
        core(16'h9CA6);
        core(16'h84A6);
        core(16'h6AF8);
        core(16'h6AF7);
        core(16'h6AF6);
        core(16'h88A6);
        for (int r = 0; r < 2; r++) begin
            core({8'h0E, 8'h7F + 8'(r * 64)});
            core(16'h6EF6);
            note(nvs_pkg::NVS_OP_ROW, 22'h000040 + 22'(r * 64), 8'h00);
            launch(1);
            core(16'h0000);
            check(exp_q.size(), 0);
            poll(8'h94);
            prog.discharge();
        end
        core(16'h94A6);
        $display("test row erase done");
        core(16'h8CA6);
        core(16'h84A6);
        launch(0);
        core(16'h0000);
        poll(8'hD4);
        core(16'h94A6);
        $display("test refused target done");
        core(16'h0E3C);
        core(16'h6EF8);
        core(16'h0E00);
        core(16'h6EF7);
        core(16'h0E05);
        core(16'h6EF6);
        prog.frame(4'hC, 16'h0F0F, rd);
        core(16'h0E04);
        core(16'h6EF6);
        note(nvs_pkg::NVS_OP_BULK, 22'h000000, 8'h00);
        prog.frame(4'hC, 16'h8F8F, rd);
        core(16'h0000);
        check(exp_q.size(), 1);
        core(16'h0000);
        check(exp_q.size(), 0);
        check(busy, 0);
        $display("test bulk erase done");
        final_report();
    end
endmodule // nvs_sequencer_tb
